// >>> power_sequencer_regs.svh
// register offsets, field positions, reset values and timing figures of the power sequencer
// How it works
// - stored buck and linear order fields, 100 and 111
// - off state watches only the button input
// - 50ms debounce, then keypress low, then ramp
// - external regulator enable rises first
// - after 1ms, linear two and buck three
// - linear two good starts buck one, two
// - enable pin high switches linear one on
// - reset released 20ms after buck one good
// - mask bit set keeps buck three on
// - pin low drops buck three, linear one
// - pin high again restores both rails
// - deep request keeps only battery path and buck two, reset low
// - button low wakes, clears deep request itself
// - undervoltage restores defaults, clears memory flag
// - hold-on input keeps power after release
`ifndef POWER_SEQUENCER_REGS_SVH
`define POWER_SEQUENCER_REGS_SVH

// register word offsets on the plain bus
`define REG_CONTROL_ONE     8'h00
`define REG_CONTROL_TWO     8'h01
`define REG_STATUS          8'h02
`define REG_INT_STATUS      8'h03
`define REG_INT_MASK        8'h04

// control_register_one fields
`define BUCK_SEQ_LSB        0
`define LINEAR_SEQ_LSB      4
`define CONTROL_ONE_RESET   8'h74

// control_register_two fields
`define MASK_BIT            0
`define MEM_FLAG_BIT        1
`define DEEP_REQ_BIT        2
`define CONTROL_TWO_RESET   8'h01

// interrupt bits
`define INT_KEYPRESS        0
`define INT_DEEP_WAKE       1
`define INT_SLEEP_ENTRY     2
`define INT_RESET_RELEASE   3

// timing figures
`define CLOCK_HZ            25000000
`define DEBOUNCE_MS         50
`define EXT_DELAY_MS        1
`define RESET_DELAY_MS      20

`endif

// >>> power_sequencer_pkg.sv
// types shared by the power sequencer
package power_sequencer_pkg;

	// one-hot sequencing states
	typedef enum logic [6:0] {
		ST_OFF      = 7'h01,
		ST_WAKE     = 7'h02,
		ST_EXT      = 7'h04,
		ST_RAMP_L2  = 7'h08,
		ST_RAMP_B12 = 7'h10,
		ST_ACTIVE   = 7'h20,
		ST_DEEP     = 7'h40
	} seq_state_type;

endpackage

// >>> sleep_aware_power_sequencer.sv
// power-up, sleep and deep-sleep sequencer with its register port
`timescale 1ns/1ps
`include "power_sequencer_regs.svh"

module sleep_aware_power_sequencer #(
	parameter int DEBOUNCE_CYCLES = (`DEBOUNCE_MS * `CLOCK_HZ) / 1000,
	parameter int EXT_CYCLES      = (`EXT_DELAY_MS * `CLOCK_HZ) / 1000,
	parameter int RESET_CYCLES    = (`RESET_DELAY_MS * `CLOCK_HZ) / 1000,
	parameter int CNT_W           = 21
) (
	input  wire logic       i_sys_clk,                   // system clock, 25 MHz
	input  wire logic       i_rst,                       // synchronous reset, active high
	input  wire logic       i_power_button_in_n,         // push button, low while pressed
	input  wire logic       i_buck_three_enable_pin,     // processor power enable
	input  wire logic       i_hold_on,                   // keeps power after release
	input  wire logic       i_linear_two_good,           // linear two power-good comparator
	input  wire logic       i_buck_one_good,             // buck one power-good comparator
	input  wire logic       i_undervoltage,              // supply below lockout threshold
	input  wire logic [7:0] i_addr,                      // register address
	input  wire logic [7:0] i_wr_data,                   // register write data
	input  wire logic       i_wr_en,                     // write strobe
	input  wire logic       i_rd_en,                     // read strobe
	output logic      [7:0] o_rd_data,                   // read data, cycle after strobe
	output logic            o_keypress_out_n,            // low while a press is reported
	output logic            o_system_rail_en,            // battery path switch
	output logic            o_external_regulator_enable, // external rtc io regulator
	output logic            o_linear_one_en,             // processor pll supply
	output logic            o_linear_two_en,             // linear two enable
	output logic            o_buck_one_en,               // buck one enable
	output logic            o_buck_two_en,               // buck two, memory supply
	output logic            o_buck_three_en,             // buck three, domain supply
	output logic            o_power_good_reset_out_n,    // processor reset, low = reset
	output logic            o_irq                        // level interrupt
);

	// synchronised pin levels, second stage only is read
	logic [5:0] pin_meta_q;                 // first stage
	logic [5:0] pin_sync_q;                 // second stage
	logic       button_pressed;             // button held low
	logic       enable_pin;                 // buck three enable pin level
	logic       hold_on;                    // hold-on level
	logic       l2_good;                    // linear two in range
	logic       b1_good;                    // buck one in range
	logic       uvlo;                       // undervoltage level
	logic       enable_pin_prev_q;          // for sleep entry edge

	// debounce
	logic [CNT_W-1:0] debounce_cnt_q;       // time the button has been held
	logic             debounced_q;          // press qualified
	logic             debounced_prev_q;     // for keypress edge

	// sequencer
	power_sequencer_pkg::seq_state_type state_q;
	power_sequencer_pkg::seq_state_type state_d;
	logic [CNT_W-1:0] step_cnt_q;           // ext and reset delay timer
	logic             ext_done;             // ext delay passed
	logic             reset_done;           // reset delay passed

	// registers
	logic [7:0] control_one_q;              // order selects
	logic [7:0] control_two_q;              // mask, memory flag, deep request
	logic [3:0] int_status_q;               // sticky events
	logic [3:0] int_mask_q;                 // interrupt enables
	logic [3:0] events;                     // one-cycle event pulses
	logic [7:0] rd_mux;                     // read selection
	logic       mask_bit;                   // buck three ignores the pin
	logic       deep_req;                   // deep sleep requested
	logic       wake_from_deep;             // deep exit pulse
	logic       reg_clear;                  // reset or lockout

	// two-flop synchroniser for every asynchronous pin
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			pin_meta_q <= 6'h01;
			pin_sync_q <= 6'h01;
		end else begin
			pin_meta_q <= {i_undervoltage, i_buck_one_good, i_linear_two_good,
				i_hold_on, i_buck_three_enable_pin, i_power_button_in_n};
			pin_sync_q <= pin_meta_q;
		end
	end

	assign button_pressed = ~pin_sync_q[0];
	assign enable_pin     = pin_sync_q[1];
	assign hold_on        = pin_sync_q[2];
	assign l2_good        = pin_sync_q[3];
	assign b1_good        = pin_sync_q[4];
	assign uvlo           = pin_sync_q[5];

	// lockout acts like a reset on all control state
	assign reg_clear = i_rst | uvlo;

	assign mask_bit = control_two_q[`MASK_BIT];
	assign deep_req = control_two_q[`DEEP_REQ_BIT];

	// debounce counter runs in every state so a press is reported in any state; deep wake uses the raw level
	always_ff @(posedge i_sys_clk) begin
		if (reg_clear) begin
			debounce_cnt_q <= '0;
			debounced_q    <= 1'b0;
		end else if (!button_pressed) begin
			// a bounce back high starts the wait again
			debounce_cnt_q <= '0;
			debounced_q    <= 1'b0;
		end else if (debounce_cnt_q == CNT_W'(DEBOUNCE_CYCLES - 1)) begin
			debounced_q <= 1'b1;
		end else begin
			debounce_cnt_q <= debounce_cnt_q + 1'b1;
		end
	end

	// edge memories for event pulses
	always_ff @(posedge i_sys_clk) begin
		if (reg_clear) begin
			debounced_prev_q  <= 1'b0;
			enable_pin_prev_q <= 1'b0;
		end else begin
			debounced_prev_q  <= debounced_q;
			enable_pin_prev_q <= enable_pin;
		end
	end

	// the step timer only needs to compare against the current state's figure
	assign ext_done   = (step_cnt_q == CNT_W'(EXT_CYCLES - 1));
	assign reset_done = (step_cnt_q == CNT_W'(RESET_CYCLES - 1));

	// deep exit is taken on the raw synchronised level, the processor is asleep
	assign wake_from_deep = (state_q == power_sequencer_pkg::ST_DEEP) && button_pressed;

	// next-state logic of the sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			power_sequencer_pkg::ST_OFF: begin
				// only the button is watched while off
				if (button_pressed) begin
					state_d = power_sequencer_pkg::ST_WAKE;
				end
			end
			power_sequencer_pkg::ST_WAKE: begin
				if (!button_pressed) begin
					state_d = power_sequencer_pkg::ST_OFF;
				end else if (debounced_q) begin
					state_d = power_sequencer_pkg::ST_EXT;
				end
			end
			power_sequencer_pkg::ST_EXT: begin
				if (ext_done) begin
					state_d = power_sequencer_pkg::ST_RAMP_L2;
				end
			end
			power_sequencer_pkg::ST_RAMP_L2: begin
				if (l2_good) begin
					state_d = power_sequencer_pkg::ST_RAMP_B12;
				end
			end
			power_sequencer_pkg::ST_RAMP_B12: begin
				if (b1_good && reset_done) begin
					state_d = power_sequencer_pkg::ST_ACTIVE;
				end
			end
			power_sequencer_pkg::ST_ACTIVE: begin
				if (deep_req) begin
					state_d = power_sequencer_pkg::ST_DEEP;
				end
			end
			power_sequencer_pkg::ST_DEEP: begin
				if (wake_from_deep) begin
					state_d = power_sequencer_pkg::ST_EXT;
				end
			end
			default: begin
				state_d = power_sequencer_pkg::ST_OFF;
			end
		endcase
		// from external enable up to active, releasing the button without hold-on shuts down; deep sleep does not
		if (!button_pressed && !hold_on &&
			(state_q == power_sequencer_pkg::ST_EXT ||
			 state_q == power_sequencer_pkg::ST_RAMP_L2 ||
			 state_q == power_sequencer_pkg::ST_RAMP_B12 ||
			 state_q == power_sequencer_pkg::ST_ACTIVE)) begin
			state_d = power_sequencer_pkg::ST_OFF;
		end
	end

	// state register
	always_ff @(posedge i_sys_clk) begin
		if (reg_clear) begin
			state_q <= power_sequencer_pkg::ST_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// step timer, cleared on every state change
	always_ff @(posedge i_sys_clk) begin
		if (reg_clear || state_d != state_q) begin
			step_cnt_q <= '0;
		end else if (state_q == power_sequencer_pkg::ST_EXT && !ext_done) begin
			step_cnt_q <= step_cnt_q + 1'b1;
		end else if (state_q == power_sequencer_pkg::ST_RAMP_B12) begin
			// the delay counts only while buck one stays in regulation
			if (!b1_good) begin
				step_cnt_q <= '0;
			end else if (!reset_done) begin
				step_cnt_q <= step_cnt_q + 1'b1;
			end
		end
	end

	// rail and pin outputs, all registered so they never glitch at the pins
	always_ff @(posedge i_sys_clk) begin
		if (reg_clear) begin
			o_system_rail_en            <= 1'b0;
			o_external_regulator_enable <= 1'b0;
			o_linear_two_en             <= 1'b0;
			o_buck_one_en               <= 1'b0;
			o_buck_two_en               <= 1'b0;
			o_buck_three_en             <= 1'b0;
			o_linear_one_en             <= 1'b0;
			o_power_good_reset_out_n    <= 1'b0;
			o_keypress_out_n            <= 1'b1;
		end else begin
			o_keypress_out_n <= ~debounced_q;
			// battery path follows any state but off
			o_system_rail_en <= (state_d != power_sequencer_pkg::ST_OFF);
			// external regulator leads, dropped in deep sleep
			o_external_regulator_enable <= (state_d == power_sequencer_pkg::ST_EXT) ||
				(state_d == power_sequencer_pkg::ST_RAMP_L2) ||
				(state_d == power_sequencer_pkg::ST_RAMP_B12) ||
				(state_d == power_sequencer_pkg::ST_ACTIVE);
			o_linear_two_en <= (state_d == power_sequencer_pkg::ST_RAMP_L2) ||
				(state_d == power_sequencer_pkg::ST_RAMP_B12) ||
				(state_d == power_sequencer_pkg::ST_ACTIVE);
			o_buck_one_en <= (state_d == power_sequencer_pkg::ST_RAMP_B12) ||
				(state_d == power_sequencer_pkg::ST_ACTIVE);
			// buck two keeps the memory alive through deep sleep
			o_buck_two_en <= (state_d == power_sequencer_pkg::ST_RAMP_B12) ||
				(state_d == power_sequencer_pkg::ST_ACTIVE) ||
				(state_d == power_sequencer_pkg::ST_DEEP);
			// buck three rides with linear two unless the pin has control
			o_buck_three_en <= ((state_d == power_sequencer_pkg::ST_RAMP_L2) ||
				(state_d == power_sequencer_pkg::ST_RAMP_B12) ||
				(state_d == power_sequencer_pkg::ST_ACTIVE)) &&
				(mask_bit || enable_pin);
			// linear one always follows the enable pin once buck one ramps
			o_linear_one_en <= ((state_d == power_sequencer_pkg::ST_RAMP_B12) ||
				(state_d == power_sequencer_pkg::ST_ACTIVE)) && enable_pin;
			o_power_good_reset_out_n <= (state_d == power_sequencer_pkg::ST_ACTIVE);
		end
	end

	// control_register_one: order selects, stored and readable
	always_ff @(posedge i_sys_clk) begin
		if (reg_clear) begin
			control_one_q <= `CONTROL_ONE_RESET;
		end else if (i_wr_en && i_addr == `REG_CONTROL_ONE) begin
			control_one_q <= i_wr_data & 8'h77;
		end
	end

	// control_register_two: mask, memory flag and deep request
	always_ff @(posedge i_sys_clk) begin
		if (reg_clear) begin
			// lockout brings back the mask default and forgets saved memory
			control_two_q <= `CONTROL_TWO_RESET;
		end else if (wake_from_deep) begin
			// the processor cannot write while in deep sleep, so no conflict
			control_two_q[`DEEP_REQ_BIT] <= 1'b0;
		end else if (i_wr_en && i_addr == `REG_CONTROL_TWO) begin
			control_two_q <= i_wr_data & 8'h07;
		end
	end

	// events that feed the sticky status
	assign events[`INT_KEYPRESS]      = debounced_q & ~debounced_prev_q;
	assign events[`INT_DEEP_WAKE]     = wake_from_deep;
	assign events[`INT_SLEEP_ENTRY]   = enable_pin_prev_q & ~enable_pin &
		(state_q == power_sequencer_pkg::ST_ACTIVE);
	assign events[`INT_RESET_RELEASE] = (state_d == power_sequencer_pkg::ST_ACTIVE) &&
		(state_q != power_sequencer_pkg::ST_ACTIVE);

	// sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge i_sys_clk) begin
		if (reg_clear) begin
			int_status_q <= 4'h0;
		end else if (i_wr_en && i_addr == `REG_INT_STATUS) begin
			int_status_q <= (int_status_q & ~i_wr_data[3:0]) | events;
		end else begin
			int_status_q <= int_status_q | events;
		end
	end

	// interrupt mask
	always_ff @(posedge i_sys_clk) begin
		if (reg_clear) begin
			int_mask_q <= 4'h0;
		end else if (i_wr_en && i_addr == `REG_INT_MASK) begin
			int_mask_q <= i_wr_data[3:0];
		end
	end

	assign o_irq = |(int_status_q & int_mask_q);

	// read selection; unmapped addresses read zero
	always_comb begin
		case (i_addr)
			`REG_CONTROL_ONE: rd_mux = control_one_q;
			`REG_CONTROL_TWO: rd_mux = control_two_q;
			`REG_STATUS:      rd_mux = {1'b0, state_q};
			`REG_INT_STATUS:  rd_mux = {4'h0, int_status_q};
			`REG_INT_MASK:    rd_mux = {4'h0, int_mask_q};
			default:          rd_mux = 8'h00;
		endcase
	end

	// read data stands one cycle after the strobe only
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_rd_data <= 8'h00;
		end else if (i_rd_en) begin
			o_rd_data <= rd_mux;
		end else begin
			o_rd_data <= 8'h00;
		end
	end

endmodule

// >>> sleep_aware_power_sequencer_sva.sv
// checker for the rail order, reset and deep-sleep behaviour at the sequencer ports
`timescale 1ns/1ps
module power_seq_sva #(
	parameter int EXT_CYCLES   = 4,
	parameter int RESET_CYCLES = 6
) (
	input wire logic       i_sys_clk,
	input wire logic       i_rst,
	input wire logic       i_rd_en,
	input wire logic       i_undervoltage,
	input wire logic [7:0] o_rd_data,
	input wire logic       o_keypress_out_n,
	input wire logic       o_system_rail_en,
	input wire logic       o_external_regulator_enable,
	input wire logic       o_linear_one_en,
	input wire logic       o_linear_two_en,
	input wire logic       o_buck_one_en,
	input wire logic       o_buck_two_en,
	input wire logic       o_buck_three_en,
	input wire logic       o_power_good_reset_out_n
);
	// one clock domain, so clock and disable are given once
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	// the external supply leads the first internal rails by several cycles
	a_ext_lead_rails: assert property ($rose(o_external_regulator_enable) |-> !o_linear_two_en [*3])
		else $error("linear two rose too soon after external enable");
	a_buck_one_order: assert property (o_buck_one_en |-> o_linear_two_en && o_external_regulator_enable)
		else $error("buck one on before linear two");
	a_buck_three_l2: assert property (o_buck_three_en |-> o_linear_two_en)
		else $error("buck three on without linear two");
	a_pll_needs_b1: assert property (o_linear_one_en |-> o_buck_one_en)
		else $error("linear one on before buck one");
	// buck one must be on at release and already on RESET_CYCLES cycles before it
	a_reset_delay: assert property ($rose(o_power_good_reset_out_n) |-> o_buck_one_en && $past(o_buck_one_en, RESET_CYCLES))
		else $error("reset released early");
	// only deep sleep keeps buck two without linear two
	a_deep_only_b2: assert property (o_buck_two_en && !o_linear_two_en |-> !o_buck_one_en && !o_buck_three_en && !o_linear_one_en && !o_power_good_reset_out_n)
		else $error("deep sleep left a rail on");
	a_debounce_wait: assert property ($rose(o_system_rail_en) |-> o_keypress_out_n [*7])
		else $error("keypress reported before debounce");
	a_uvlo_all_off: assert property (i_undervoltage [*4] |-> !o_system_rail_en && !o_buck_two_en)
		else $error("rails on during undervoltage");
	a_off_state_quiet: assert property (!o_system_rail_en |-> !o_buck_two_en && !o_external_regulator_enable)
		else $error("rail on while off");
	a_rd_idle_zero: assert property (!$past(i_rd_en) |-> o_rd_data == 8'h00)
		else $error("read data without strobe");
endmodule

bind sleep_aware_power_sequencer power_seq_sva #(
	.EXT_CYCLES(EXT_CYCLES),
	.RESET_CYCLES(RESET_CYCLES)
) u_sva (.i_sys_clk, .i_rst, .i_rd_en, .i_undervoltage, .o_rd_data, .o_keypress_out_n,
	.o_system_rail_en, .o_external_regulator_enable, .o_linear_one_en, .o_linear_two_en,
	.o_buck_one_en, .o_buck_two_en, .o_buck_three_en, .o_power_good_reset_out_n);

// >>> rail_partner.sv
// power-good comparators of linear two and buck one driven by the sequencer
`timescale 1ns/1ps
module rail_partner (
	input  wire logic i_sys_clk,
	input  wire logic i_linear_two_en,
	input  wire logic i_buck_one_en,
	output logic      o_linear_two_good,
	output logic      o_buck_one_good
);
	logic [2:0] l2_q; // ramp time of linear two
	logic [2:0] b1_q; // ramp time of buck one

	// a rail needs three cycles to ramp, but a dropped enable loses good at once
	always_ff @(posedge i_sys_clk) begin
		l2_q <= {l2_q[1:0], i_linear_two_en};
		b1_q <= {b1_q[1:0], i_buck_one_en};
	end
	assign o_linear_two_good = (&l2_q) & i_linear_two_en;
	assign o_buck_one_good   = (&b1_q) & i_buck_one_en;
endmodule

// >>> test_sleep_aware_power_sequencer.sv
// self-checking bench of the power sequencer
`timescale 1ns/1ps
module test_sleep_aware_power_sequencer;
	logic       i_sys_clk, i_rst, i_power_button_in_n, i_buck_three_enable_pin, i_hold_on;
	logic       i_undervoltage, i_wr_en, i_rd_en, l2_good, b1_good, seen_ext;
	logic [7:0] i_addr, i_wr_data, o_rd_data, rails;
	logic       o_keypress_out_n, o_system_rail_en, o_external_regulator_enable, o_irq;
	logic       o_linear_one_en, o_linear_two_en, o_buck_one_en, o_buck_two_en;
	logic       o_buck_three_en, o_power_good_reset_out_n;
	int         n_fail, tests_run;
	logic [16:0] rows [12] = '{17'h00074, 17'h00101, 17'h00400, 17'h00201, 17'h00700,
		17'h10755, 17'h00700, 17'h10077, 17'h00077, 17'h10074, 17'h10408, 17'h00408};

	// rails packed as sys, ext, l2, b3, b1, b2, l1, reset release
	assign rails = {o_system_rail_en, o_external_regulator_enable, o_linear_two_en,
		o_buck_three_en, o_buck_one_en, o_buck_two_en, o_linear_one_en, o_power_good_reset_out_n};

	sleep_aware_power_sequencer #(.DEBOUNCE_CYCLES(8), .EXT_CYCLES(4), .RESET_CYCLES(6)) DUT (
		.i_sys_clk, .i_rst, .i_power_button_in_n, .i_buck_three_enable_pin, .i_hold_on,
		.i_linear_two_good(l2_good), .i_buck_one_good(b1_good), .i_undervoltage, .i_addr,
		.i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .o_keypress_out_n, .o_system_rail_en,
		.o_external_regulator_enable, .o_linear_one_en, .o_linear_two_en, .o_buck_one_en,
		.o_buck_two_en, .o_buck_three_en, .o_power_good_reset_out_n, .o_irq);
	rail_partner u_rails (.i_sys_clk, .i_linear_two_en(o_linear_two_en),
		.i_buck_one_en(o_buck_one_en), .o_linear_two_good(l2_good), .o_buck_one_good(b1_good));

	// remembers any glimpse of the external enable, short presses must leave none
	always @(posedge i_sys_clk) begin
		if (i_rst) seen_ext <= 1'b0;
		else if (o_external_regulator_enable) seen_ext <= 1'b1;
	end

	task automatic tally_and_finish();
		if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wr_data <= d;
		i_wr_en <= 1'b1;
		@(posedge i_sys_clk);
		i_wr_en <= 1'b0;
		// one edge passes so a following call never sets the strobe in the same step
		@(posedge i_sys_clk);
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		i_addr <= a;
		i_rd_en <= 1'b1;
		@(posedge i_sys_clk);
		i_rd_en <= 1'b0;
		// the data launched at this edge is gone again at the next one
		#1 chk(o_rd_data, exp);
		@(posedge i_sys_clk);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask
	// bounded wait for one rail bit, a hang ends the run
	task automatic wt(input int k, input logic v);
		int n;
		for (n = 0; n < 400 && rails[k] !== v; n++) begin
			@(posedge i_sys_clk);
			#1;
		end
		if (n == 400) begin
			n_fail++;
			tally_and_finish();
		end
	endtask

	initial begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end

	initial begin
		{i_rst, i_power_button_in_n, i_buck_three_enable_pin} = 3'b110;
		{i_hold_on, i_undervoltage, i_wr_en, i_rd_en} = 4'h0;
		{i_addr, i_wr_data, n_fail, tests_run} = '0;
		cyc(3);
		i_rst <= 1'b0;
		chk(rails, 8'h00);
		chk({o_irq, o_keypress_out_n, o_rd_data[5:0]}, 8'h40);
		// table rows: write flag, address, data or expected read
		foreach (rows[i]) begin
			if (rows[i][16]) wr(rows[i][15:8], rows[i][7:0]);
			else rd(rows[i][15:8], rows[i][7:0]);
		end
		// two short presses split by a one-cycle release start the battery path only, never the external enable
		i_power_button_in_n <= 1'b0;
		cyc(6);
		i_power_button_in_n <= 1'b1;
		cyc(1);
		i_power_button_in_n <= 1'b0;
		cyc(6);
		i_power_button_in_n <= 1'b1;
		wt(7, 1'b0);
		chk({seen_ext, rails[6:0]}, 8'h00);
		// full power-up; the processor pin stays low until buck one runs
		i_power_button_in_n <= 1'b0;
		wt(6, 1'b1);
		chk({o_keypress_out_n, rails[6:0]}, 8'h40);
		i_hold_on <= 1'b1;
		wt(3, 1'b1);
		chk(rails, 8'hfc);
		i_buck_three_enable_pin <= 1'b1;
		wt(0, 1'b1);
		chk(rails, 8'hff);
		i_power_button_in_n <= 1'b1;
		cyc(4);
		chk({o_irq, rails[6:0]}, 8'hff);
		rd(8'h03, 8'h09);
		rd(8'h02, 8'h20);
		wr(8'h03, 8'h0f);
		rd(8'h03, 8'h00);
		chk({7'h00, o_irq}, 8'h00);
		// pin sleep after the mask is cleared
		wr(8'h01, 8'h00);
		i_buck_three_enable_pin <= 1'b0;
		wt(4, 1'b0);
		chk(rails, 8'hed);
		wr(8'h04, 8'h04);
		#1 chk({7'h00, o_irq}, 8'h01);
		i_buck_three_enable_pin <= 1'b1;
		wt(4, 1'b1);
		chk(rails, 8'hff);
		wr(8'h03, 8'h0f);
		// deep sleep with the memory flag set first, woken by the button
		wr(8'h01, 8'h02);
		wr(8'h01, 8'h06);
		wt(5, 1'b0);
		chk(rails, 8'h84);
		rd(8'h01, 8'h06);
		i_power_button_in_n <= 1'b0;
		wt(0, 1'b1);
		i_power_button_in_n <= 1'b1;
		chk(rails, 8'hff);
		rd(8'h01, 8'h02);
		wr(8'h01, 8'h00);
		rd(8'h01, 8'h00);
		// undervoltage drops everything and restores register defaults
		wr(8'h01, 8'h02);
		i_undervoltage <= 1'b1;
		wt(7, 1'b0);
		cyc(2);
		i_undervoltage <= 1'b0;
		chk(rails, 8'h00);
		rd(8'h01, 8'h01);
		rd(8'h04, 8'h00);
		tally_and_finish();
	end
endmodule
